// ===== core/cfsa_pkg.sv
package cfsa_pkg;
   // command types as decoded by the front end
   typedef enum logic [1:0] {
      INS_UNBLOCK = 2'b00,
      INS_DEACT = 2'b01,
      INS_ACT = 2'b10,
      INS_AUTH = 2'b11
   } cfsa_ins_e;

   // kinds of file operation asked of the gate
   typedef enum logic [1:0] {
      OP_SELECT = 2'b00,
      OP_ACTIVATE = 2'b01,
      OP_OTHER = 2'b10
   } cfsa_op_e;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_DATA = 3'b001,
      ST_EXEC = 3'b010,
      ST_RESP = 3'b011
   } cfsa_state_e;

   // selection-control codes for file commands
   localparam logic [7:0] SEL_FID = 8'h00;
   localparam logic [7:0] SEL_PATH_MF = 8'h08;
   localparam logic [7:0] SEL_PATH_DF = 8'h09;

   // unblock data layout: code in bytes 1..8, new pin in 9..16
   localparam logic [7:0] UNBLK_LC = 8'h10;
   localparam int UNBLK_HALF_BITS = 64;

   // key reference fields
   localparam int KEY_SCOPE_BIT = 7;
   localparam int KEY_RSV_HI = 6;
   localparam int KEY_RSV_LO = 5;
   localparam int KEY_NUM_HI = 4;

   // status words
   localparam logic [15:0] SW_OK = 16'h9000;
   localparam logic [11:0] SW_RETRY_HI = 12'h63C;
   localparam logic [15:0] SW_WRONG_LEN = 16'h6700;
   localparam logic [15:0] SW_SEC_FAIL = 16'h6982;
   localparam logic [15:0] SW_COND_USE = 16'h6985;
   localparam logic [15:0] SW_NOT_FOUND = 16'h6A82;
   localparam logic [15:0] SW_WRONG_P1P2 = 16'h6A86;
   localparam logic [15:0] SW_RESET = 16'h0000;

   localparam logic [15:0] MIX_RESET = 16'h0000;
endpackage

// ===== core/cfsa_auth_mix.sv
`timescale 1ns/10ps
`default_nettype none
module cfsa_auth_mix (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic absorb,
   input wire logic squeeze,
   input wire logic [7:0] din,
   input wire logic [7:0] secret,
   output logic [7:0] dout
);
   logic [15:0] state_r;
   logic [15:0] state_nxt;
   wire [15:0] rot = {state_r[14:0], state_r[15]};
   wire [15:0] fb = {state_r[14:0], state_r[15] ^ state_r[13]};

   // challenge folds into the keyed state; squeezing keeps stirring the secret in
   // secret and challenge sit in opposite halves so the output fold cannot cancel the challenge
   assign state_nxt = clear ? cfsa_pkg::MIX_RESET :
                      absorb ? (rot ^ {secret, din}) :
                      squeeze ? (fb ^ {8'h00, secret}) : state_r;
   assign dout = state_r[7:0] ^ state_r[15:8];

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_r <= cfsa_pkg::MIX_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end
endmodule
`default_nettype wire

// ===== core/cfsa_cmd.sv
// Function
// R1 - unblock data is empty (query) or sixteen bytes: code then new pin
// R2 - deactivation sets the file's deactivated flag, reversibly
// R3 - deactivation only when its access condition holds, else refused
// R4 - successful deactivate or activate makes target the current file
// R5 - failed deactivate or activate leaves current file and directory unchanged
// R6 - deactivated file refuses all operations but select and activate
// R7 - selection control: 00 file id, 08 path from root, 09 from directory
// R8 - both parameters zero and no data means the current file
// R9 - successful activation clears the deactivated flag
// R10 - activation only when its access condition holds
// R11 - terminal selects an application before authenticating
// R12 - authentication output mixes terminal challenge with the card secret
// R13 - algorithm byte zero means algorithm implied by the application
// R14 - key byte: scope bit, two zero bits, number 01 to 1F
// R15 - key byte zero means key implied by the application
// R16 - data count must equal declared length; reply gives requested byte count
// R17 - empty unblock returns retries left in the status low nibble
// R18 - reserved parameter codes give error status and touch no state; SEL_CTRL still takes the reserved P1 and the mixer is cleared
`timescale 1ns/10ps
`default_nettype none
module cfsa_cmd #(
   parameter int NUM_FILES = 8,
   parameter int FW = $clog2(NUM_FILES)
) (
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic CMD_VALID,
   input wire logic [1:0] CMD_INS,
   input wire logic [7:0] CMD_P1,
   input wire logic [7:0] CMD_P2,
   input wire logic [7:0] CMD_LC,
   input wire logic [7:0] CMD_LE,
   input wire logic APP_SELECTED,
   input wire logic DATA_VALID,
   input wire logic DATA_LAST,
   input wire logic [7:0] DATA_BYTE,
   input wire logic [FW-1:0] TARGET_FILE,
   input wire logic TARGET_FOUND,
   input wire logic ACC_DEACT_OK,
   input wire logic ACC_REACT_OK,
   input wire logic [7:0] SECRET,
   input wire logic [3:0] UNBLK_RETRIES,
   input wire logic OP_REQ,
   input wire logic [1:0] OP_KIND,
   input wire logic [FW-1:0] OP_FILE,
   output logic BUSY,
   output logic DONE,
   output logic [15:0] SW,
   output logic [7:0] SEL_CTRL,
   output logic [FW-1:0] CUR_EF,
   output logic [NUM_FILES-1:0] FILE_DEACT,
   output logic UNBLK_REQ,
   output logic [63:0] UNBLK_CODE,
   output logic [63:0] NEW_PIN,
   output logic ALG_IMPLICIT,
   output logic KEY_IMPLICIT,
   output logic KEY_SPECIFIC,
   output logic [4:0] KEY_NUM,
   output logic RESP_VALID,
   output logic [7:0] RESP_BYTE,
   output logic OP_GRANT,
   output logic OP_DENY
);
   cfsa_pkg::cfsa_state_e st_r, st_nxt;
   logic [1:0] ins_r;
   logic [7:0] p1_r, p2_r, lc_r, le_r, cnt_r, cnt_nxt;
   logic [127:0] buf_r;
   logic [15:0] sw_r, sw_nxt;
   logic done_r, done_nxt, unblk_r, unblk_nxt;
   logic [FW-1:0] cur_ef_r;
   logic [NUM_FILES-1:0] deact_r;
   logic alg_imp_r, key_imp_r, key_spec_r;
   logic [4:0] key_num_r;
   logic resp_v_r, grant_r, deny_r;
   logic busy_r;
   logic [7:0] resp_r;
   wire [7:0] mix_dout;

   // header checks done as the header arrives
   wire idle = (st_r == cfsa_pkg::ST_IDLE);
   wire take = idle && CMD_VALID;
   wire is_unblk = (CMD_INS == cfsa_pkg::INS_UNBLOCK);
   wire is_auth = (CMD_INS == cfsa_pkg::INS_AUTH);
   wire is_file = !is_unblk && !is_auth;
   wire sel_ok = (CMD_P1 == cfsa_pkg::SEL_FID) || (CMD_P1 == cfsa_pkg::SEL_PATH_MF) ||
                 (CMD_P1 == cfsa_pkg::SEL_PATH_DF); // [R7]
   wire key_rsv = (CMD_P2[cfsa_pkg::KEY_RSV_HI:cfsa_pkg::KEY_RSV_LO] != 2'b00) ||
                  ((CMD_P2 != 8'h00) && (CMD_P2[cfsa_pkg::KEY_NUM_HI:0] == 5'h00)); // [R14]
   wire path_no_data = (CMD_P1 != cfsa_pkg::SEL_FID) && (CMD_LC == 8'h00);
   wire [15:0] hdr_sw =
      is_unblk ? ((CMD_P1 != 8'h00) ? cfsa_pkg::SW_WRONG_P1P2 :
                  ((CMD_LC != 8'h00) && (CMD_LC != cfsa_pkg::UNBLK_LC)) ? cfsa_pkg::SW_WRONG_LEN :
                  cfsa_pkg::SW_OK) : // [R1]
      is_file ? ((!sel_ok || (CMD_P2 != 8'h00)) ? cfsa_pkg::SW_WRONG_P1P2 : // [R18]
                 path_no_data ? cfsa_pkg::SW_WRONG_LEN : cfsa_pkg::SW_OK) :
      (!APP_SELECTED ? cfsa_pkg::SW_COND_USE : // [R11]
       key_rsv ? cfsa_pkg::SW_WRONG_P1P2 :
       (CMD_LC == 8'h00) ? cfsa_pkg::SW_WRONG_LEN : cfsa_pkg::SW_OK);
   wire hdr_err = (hdr_sw != cfsa_pkg::SW_OK);

   // data phase: the declared length must meet the terminal's last-byte mark
   wire in_data = (st_r == cfsa_pkg::ST_DATA) && DATA_VALID;
   wire last_byte = ((cnt_r + 8'h01) == lc_r);
   wire len_bad = in_data && (DATA_LAST != last_byte); // [R16]

   // target of a file command: current file when nothing else is named
   wire use_cur = (p1_r == 8'h00) && (p2_r == 8'h00) && (lc_r == 8'h00); // [R8]
   wire [FW-1:0] tgt = use_cur ? cur_ef_r : TARGET_FILE;
   wire found = use_cur || TARGET_FOUND;
   wire exec = (st_r == cfsa_pkg::ST_EXEC);
   wire exec_file = exec && ((ins_r == cfsa_pkg::INS_DEACT) || (ins_r == cfsa_pkg::INS_ACT));
   wire acc_ok = (ins_r == cfsa_pkg::INS_DEACT) ? ACC_DEACT_OK : ACC_REACT_OK; // [R3] [R10]
   wire file_ok = exec_file && found && acc_ok;
   wire exec_deact_ok = file_ok && (ins_r == cfsa_pkg::INS_DEACT);
   wire exec_act_ok = file_ok && (ins_r == cfsa_pkg::INS_ACT);
   wire in_resp = (st_r == cfsa_pkg::ST_RESP);
   wire resp_last = ((cnt_r + 8'h01) == le_r);

   // sequencing of one command; errors return to idle without touching file state
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      sw_nxt = sw_r;
      done_nxt = 1'b0;
      unblk_nxt = 1'b0;
      case (st_r)
         cfsa_pkg::ST_IDLE: begin
            cnt_nxt = 8'h00;
            if (take) begin
               if (hdr_err) begin
                  sw_nxt = hdr_sw; // [R18]
                  done_nxt = 1'b1;
               end else begin
                  st_nxt = (CMD_LC == 8'h00) ? cfsa_pkg::ST_EXEC : cfsa_pkg::ST_DATA;
               end
            end
         end
         cfsa_pkg::ST_DATA: begin
            if (len_bad) begin
               sw_nxt = cfsa_pkg::SW_WRONG_LEN; // [R16]
               done_nxt = 1'b1;
               st_nxt = cfsa_pkg::ST_IDLE;
            end else if (in_data) begin
               cnt_nxt = cnt_r + 8'h01;
               if (last_byte) begin
                  st_nxt = cfsa_pkg::ST_EXEC;
               end
            end
         end
         cfsa_pkg::ST_EXEC: begin
            cnt_nxt = 8'h00;
            done_nxt = 1'b1;
            st_nxt = cfsa_pkg::ST_IDLE;
            if (ins_r == cfsa_pkg::INS_UNBLOCK) begin
               if (lc_r == 8'h00) begin
                  sw_nxt = {cfsa_pkg::SW_RETRY_HI, UNBLK_RETRIES}; // [R17]
               end else begin
                  sw_nxt = cfsa_pkg::SW_OK;
                  unblk_nxt = 1'b1; // [R1]
               end
            end else if (ins_r == cfsa_pkg::INS_AUTH) begin
               sw_nxt = cfsa_pkg::SW_OK;
               if (le_r != 8'h00) begin
                  done_nxt = 1'b0;
                  st_nxt = cfsa_pkg::ST_RESP;
               end
            end else if (!found) begin
               sw_nxt = cfsa_pkg::SW_NOT_FOUND;
            end else if (!acc_ok) begin
               sw_nxt = cfsa_pkg::SW_SEC_FAIL; // [R3] [R10]
            end else begin
               sw_nxt = cfsa_pkg::SW_OK;
            end
         end
         cfsa_pkg::ST_RESP: begin
            cnt_nxt = cnt_r + 8'h01;
            if (resp_last) begin
               done_nxt = 1'b1; // [R16]
               st_nxt = cfsa_pkg::ST_IDLE;
            end
         end
         default: begin
            st_nxt = cfsa_pkg::ST_IDLE;
         end
      endcase
   end

   // sequencer and header registers
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         st_r <= cfsa_pkg::ST_IDLE;
         busy_r <= 1'b0;
         cnt_r <= 8'h00;
         sw_r <= cfsa_pkg::SW_RESET;
         done_r <= 1'b0;
         unblk_r <= 1'b0;
         ins_r <= 2'h0;
         p1_r <= 8'h00;
         p2_r <= 8'h00;
         lc_r <= 8'h00;
         le_r <= 8'h00;
      end else begin
         st_r <= st_nxt;
         busy_r <= (st_nxt != cfsa_pkg::ST_IDLE); // flop copy of the state test, same timing
         cnt_r <= cnt_nxt;
         sw_r <= sw_nxt;
         done_r <= done_nxt;
         unblk_r <= unblk_nxt;
         if (take) begin
            ins_r <= CMD_INS;
            p1_r <= CMD_P1;
            p2_r <= CMD_P2;
            lc_r <= CMD_LC;
            le_r <= CMD_LE;
         end
      end
   end

   // unblock bytes shift in msb first, so byte one lands on top
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         buf_r <= 128'h0;
      end else if (in_data && (ins_r == cfsa_pkg::INS_UNBLOCK)) begin
         buf_r <= {buf_r[119:0], DATA_BYTE}; // [R1]
      end
   end

   // key and algorithm decode, caught at header time for the key store
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         alg_imp_r <= 1'b0;
         key_imp_r <= 1'b0;
         key_spec_r <= 1'b0;
         key_num_r <= 5'h00;
      end else if (take && is_auth && !hdr_err) begin
         alg_imp_r <= (CMD_P1 == 8'h00); // [R13]
         key_imp_r <= (CMD_P2 == 8'h00); // [R15]
         key_spec_r <= CMD_P2[cfsa_pkg::KEY_SCOPE_BIT]; // [R14]
         key_num_r <= CMD_P2[cfsa_pkg::KEY_NUM_HI:0];
      end
   end

   // current file moves only on success; directory is never written here
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         cur_ef_r <= '0;
      end else if (file_ok) begin
         cur_ef_r <= tgt; // [R4] [R5]
      end
   end

   // one deactivated flag per file, kept as its life-cycle status bit
   genvar gi;
   generate
      for (gi = 0; gi < NUM_FILES; gi = gi + 1) begin : g_lcs
         always_ff @(posedge MCLK) begin
            if (!RST_N) begin
               deact_r[gi] <= 1'b0;
            end else if (exec_deact_ok && (tgt == FW'(gi))) begin
               deact_r[gi] <= 1'b1; // [R2]
            end else if (exec_act_ok && (tgt == FW'(gi))) begin
               deact_r[gi] <= 1'b0; // [R9]
            end
         end
      end
   endgenerate

   // answer bytes registered so the port sees a clean byte per cycle
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         resp_v_r <= 1'b0;
         resp_r <= 8'h00;
         grant_r <= 1'b0;
         deny_r <= 1'b0;
      end else begin
         resp_v_r <= in_resp;
         resp_r <= in_resp ? mix_dout : 8'h00;
         grant_r <= OP_REQ && ((OP_KIND != cfsa_pkg::OP_OTHER) || !deact_r[OP_FILE]); // [R6]
         deny_r <= OP_REQ && (OP_KIND == cfsa_pkg::OP_OTHER) && deact_r[OP_FILE]; // [R6]
      end
   end

   // stateful mixer; a fresh command clears it so answers never leak across
   cfsa_auth_mix u_mix (
      .clk(MCLK),
      .rst_n(RST_N),
      .clear(take),
      .absorb(in_data && (ins_r == cfsa_pkg::INS_AUTH)), // [R12]
      .squeeze(in_resp),
      .din(DATA_BYTE),
      .secret(SECRET),
      .dout(mix_dout)
   );

   assign BUSY = busy_r;
   assign DONE = done_r;
   assign SW = sw_r;
   assign SEL_CTRL = p1_r;
   assign CUR_EF = cur_ef_r;
   assign FILE_DEACT = deact_r;
   assign UNBLK_REQ = unblk_r;
   assign UNBLK_CODE = buf_r[127:cfsa_pkg::UNBLK_HALF_BITS];
   assign NEW_PIN = buf_r[cfsa_pkg::UNBLK_HALF_BITS-1:0];
   assign ALG_IMPLICIT = alg_imp_r;
   assign KEY_IMPLICIT = key_imp_r;
   assign KEY_SPECIFIC = key_spec_r;
   assign KEY_NUM = key_num_r;
   assign RESP_VALID = resp_v_r;
   assign RESP_BYTE = resp_r;
   assign OP_GRANT = grant_r;
   assign OP_DENY = deny_r;

   property p_unblk_len;
      @(posedge MCLK) disable iff (!RST_N)
      take && is_unblk && (CMD_P1 == 8'h00) && (CMD_LC != 8'h00) && (CMD_LC != 8'h10)
      |=> DONE && (SW == 16'h6700) && !BUSY;
   endproperty
   a_unblk_len: assert property (p_unblk_len) else $error("bad unblock length not refused"); // [R1]

   property p_deact_set;
      @(posedge MCLK) disable iff (!RST_N)
      exec_deact_ok |=> FILE_DEACT[$past(tgt)] && (SW == 16'h9000);
   endproperty
   a_deact_set: assert property (p_deact_set) else $error("deactivated flag not set"); // [R2]

   property p_deact_refuse;
      @(posedge MCLK) disable iff (!RST_N)
      exec_file && found && !acc_ok |=> (SW == 16'h6982) && $stable(FILE_DEACT);
   endproperty
   a_deact_refuse: assert property (p_deact_refuse) else $error("access condition ignored"); // [R3]

   property p_cur_ef;
      @(posedge MCLK) disable iff (!RST_N)
      file_ok |=> (CUR_EF == $past(tgt)) && DONE;
   endproperty
   a_cur_ef: assert property (p_cur_ef) else $error("current file not updated"); // [R4]

   property p_fail_keep;
      @(posedge MCLK) disable iff (!RST_N)
      exec_file && !file_ok |=> $stable(CUR_EF) && (SW != 16'h9000);
   endproperty
   a_fail_keep: assert property (p_fail_keep) else $error("current file moved on failure"); // [R5]

   property p_gate;
      @(posedge MCLK) disable iff (!RST_N)
      OP_REQ && (OP_KIND == 2'b10) && FILE_DEACT[OP_FILE] |=> OP_DENY && !OP_GRANT;
   endproperty
   a_gate: assert property (p_gate) else $error("operation on deactivated file granted"); // [R6]

   property p_sel_rsv;
      @(posedge MCLK) disable iff (!RST_N)
      take && is_file && !sel_ok |=> DONE && (SW == 16'h6A86) ##1 $stable(CUR_EF);
   endproperty
   a_sel_rsv: assert property (p_sel_rsv) else $error("reserved selection accepted"); // [R7]

   property p_resp_count;
      @(posedge MCLK) disable iff (!RST_N)
      exec && (ins_r == 2'b11) && (le_r == 8'h03) |=> ##1 RESP_VALID [*3] ##1 !RESP_VALID;
   endproperty
   a_resp_count: assert property (p_resp_count) else $error("answer byte count wrong"); // [R16]

   property p_query;
      @(posedge MCLK) disable iff (!RST_N)
      exec && (ins_r == 2'b00) && (lc_r == 8'h00) |=> (SW[15:4] == 12'h63C) && (SW[3:0] == $past(UNBLK_RETRIES));
   endproperty
   a_query: assert property (p_query) else $error("retry count not reported"); // [R17]
endmodule
`default_nettype wire

// ===== tb/cfsa_term.sv
`timescale 1ns/10ps
`default_nettype none
// terminal model: one header, then its data bytes back to back
module cfsa_term (
   input wire logic clk,
   output logic cmd_valid,
   output logic [1:0] cmd_ins,
   output logic [7:0] cmd_p1,
   output logic [7:0] cmd_p2,
   output logic [7:0] cmd_lc,
   output logic [7:0] cmd_le,
   output logic data_valid,
   output logic data_last,
   output logic [7:0] data_byte
);
   // quiet lines at start
   initial begin
      {cmd_valid, data_valid, data_last, cmd_ins} = '0;
      {cmd_p1, cmd_p2, cmd_lc, cmd_le, data_byte} = '0;
   end
   // released lines show inverted values so stale data never looks valid
   task automatic send(input logic [1:0] ins, input logic [7:0] p1, input logic [7:0] p2,
      input logic [7:0] lc, input logic [7:0] le, input logic [127:0] d, input int n);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_ins <= ins;
      {cmd_p1, cmd_p2, cmd_lc, cmd_le} <= {p1, p2, lc, le};
      @(posedge clk);
      cmd_valid <= 1'b0;
      {cmd_p1, cmd_p2, cmd_lc, cmd_le} <= ~{p1, p2, lc, le};
      for (int i = 0; i < n; i++) begin
         data_valid <= 1'b1;
         data_last <= (i == n - 1);
         data_byte <= d[127 - 8 * i -: 8];
         @(posedge clk);
      end
      data_valid <= 1'b0;
      data_last <= 1'b0;
      data_byte <= ~data_byte;
   endtask
endmodule
`default_nettype wire

// ===== tb/card_file_state_auth_cmds_tb.sv
`timescale 1ns/10ps
`default_nettype none
module card_file_state_auth_cmds_tb;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic app_sel, found, acc_d, acc_r, op_req;
   logic [2:0] tgt, op_file, cur_ef;
   logic [1:0] op_kind, cmd_ins;
   logic [3:0] retries;
   logic cmd_valid, data_valid, data_last, busy, done, unblk_req, alg_imp, key_imp, key_spec;
   logic resp_valid, op_grant, op_deny;
   logic [7:0] cmd_p1, cmd_p2, cmd_lc, cmd_le, data_byte, sel_ctrl, file_deact, resp_byte;
   logic [15:0] sw;
   logic [63:0] unblk_code, new_pin;
   logic [4:0] key_num;
   int error_cnt = 0;
   int check_count = 0;
   int done_cnt = 0;
   int resp_cnt = 0;
   int req_cnt = 0;
   int cyc = 0;
   logic [7:0] secret = 8'h5A;
   logic [7:0] resp_hold = 8'h00;
   logic [15:0] rsv [5] = '{16'h0100, 16'h0400, 16'h0A00, 16'h8000, 16'h0001};

   // 25 MHz
   always #20 mclk = ~mclk;

   cfsa_term u_term (.clk(mclk), .cmd_valid(cmd_valid), .cmd_ins(cmd_ins), .cmd_p1(cmd_p1),
      .cmd_p2(cmd_p2), .cmd_lc(cmd_lc), .cmd_le(cmd_le), .data_valid(data_valid),
      .data_last(data_last), .data_byte(data_byte));

   cfsa_cmd u_dut (.MCLK(mclk), .RST_N(rst_n), .CMD_VALID(cmd_valid), .CMD_INS(cmd_ins),
      .CMD_P1(cmd_p1), .CMD_P2(cmd_p2), .CMD_LC(cmd_lc), .CMD_LE(cmd_le),
      .APP_SELECTED(app_sel), .DATA_VALID(data_valid), .DATA_LAST(data_last),
      .DATA_BYTE(data_byte), .TARGET_FILE(tgt), .TARGET_FOUND(found), .ACC_DEACT_OK(acc_d),
      .ACC_REACT_OK(acc_r), .SECRET(secret), .UNBLK_RETRIES(retries), .OP_REQ(op_req),
      .OP_KIND(op_kind), .OP_FILE(op_file), .BUSY(busy), .DONE(done), .SW(sw),
      .SEL_CTRL(sel_ctrl), .CUR_EF(cur_ef), .FILE_DEACT(file_deact), .UNBLK_REQ(unblk_req),
      .UNBLK_CODE(unblk_code), .NEW_PIN(new_pin), .ALG_IMPLICIT(alg_imp),
      .KEY_IMPLICIT(key_imp), .KEY_SPECIFIC(key_spec), .KEY_NUM(key_num),
      .RESP_VALID(resp_valid), .RESP_BYTE(resp_byte), .OP_GRANT(op_grant), .OP_DENY(op_deny));

   // pulse counters; one-cycle pulses are caught at every rising edge
   always @(posedge mclk) begin
      if (done === 1'b1) done_cnt <= done_cnt + 1;
      if (resp_valid === 1'b1) begin
         resp_cnt <= resp_cnt + 1;
         resp_hold <= resp_byte;
      end
      if (unblk_req === 1'b1) req_cnt <= req_cnt + 1;
   end

   // hang guard, far above the few hundred cycles the run needs
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         conclude();
      end
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_sw(input logic [15:0] exp);
      chk({48'h0, sw}, {48'h0, exp});
   endtask

   // answer bytes have no fixed value; only their dependence on inputs is judged
   task automatic chk_ne(input logic [7:0] got, input logic [7:0] other);
      check_count++;
      if ((got === other) || $isunknown(got)) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h expected other than %h", $time, got, other);
      end
   endtask

   // one command, bounded wait for its completion pulse
   task automatic cmd(input logic [1:0] ins, input logic [7:0] p1, input logic [7:0] p2,
      input logic [7:0] lc, input logic [7:0] le, input logic [127:0] d, input int n,
      input logic [15:0] exp_sw);
      int n0;
      n0 = done_cnt;
      u_term.send(ins, p1, p2, lc, le, d, n);
      for (int i = 0; i < 60 && done_cnt == n0; i++) @(negedge mclk);
      chk(done_cnt - n0, 1);
      chk_sw(exp_sw);
   endtask

   task automatic gate(input logic [1:0] k, input logic [2:0] f, input logic g);
      @(posedge mclk);
      op_req <= 1'b1;
      op_kind <= k;
      op_file <= f;
      @(posedge mclk);
      op_req <= 1'b0;
      @(negedge mclk);
      chk({op_grant, op_deny}, {g, !g});
   endtask

   task automatic resolve(input logic [2:0] t, input logic f, input logic ad, input logic ar);
      @(posedge mclk);
      {tgt, found, acc_d, acc_r} <= {t, f, ad, ar};
   endtask

   task automatic t_deact_cur();
      resolve(3'h7, 1'b0, 1'b1, 1'b0);
      cmd(cfsa_pkg::INS_DEACT, 8'h00, 8'h00, 8'h00, 8'h00, 128'h0, 0, cfsa_pkg::SW_OK);
      chk(file_deact, 8'h01);
      gate(cfsa_pkg::OP_OTHER, 3'h0, 1'b0);
      gate(cfsa_pkg::OP_SELECT, 3'h0, 1'b1);
      gate(cfsa_pkg::OP_ACTIVATE, 3'h0, 1'b1);
      gate(cfsa_pkg::OP_OTHER, 3'h1, 1'b1);
   endtask

   task automatic t_files();
      resolve(3'h3, 1'b1, 1'b0, 1'b0);
      cmd(cfsa_pkg::INS_DEACT, 8'h00, 8'h00, 8'h02, 8'h00, {16'h6F07, 112'h0}, 2, cfsa_pkg::SW_SEC_FAIL);
      chk(cur_ef, 3'h0);
      resolve(3'h3, 1'b1, 1'b1, 1'b0);
      cmd(cfsa_pkg::INS_DEACT, 8'h00, 8'h00, 8'h02, 8'h00, {16'h6F07, 112'h0}, 2, cfsa_pkg::SW_OK);
      chk(cur_ef, 3'h3);
      chk(file_deact, 8'h09);
      resolve(3'h5, 1'b1, 1'b1, 1'b0);
      cmd(cfsa_pkg::INS_DEACT, 8'h08, 8'h00, 8'h04, 8'h00, {32'h7F106F3A, 96'h0}, 4, cfsa_pkg::SW_OK);
      chk({cur_ef, sel_ctrl}, {3'h5, 8'h08});
      resolve(3'h6, 1'b0, 1'b1, 1'b1);
      cmd(cfsa_pkg::INS_ACT, 8'h09, 8'h00, 8'h02, 8'h00, {16'h6F3B, 112'h0}, 2, cfsa_pkg::SW_NOT_FOUND);
      chk({cur_ef, file_deact}, {3'h5, 8'h29});
      for (int i = 0; i < 5; i++) begin
         cmd(cfsa_pkg::INS_ACT, rsv[i][15:8], rsv[i][7:0], 8'h00, 8'h00, 128'h0, 0, cfsa_pkg::SW_WRONG_P1P2);
         chk({cur_ef, file_deact}, {3'h5, 8'h29});
      end
      resolve(3'h3, 1'b1, 1'b1, 1'b0);
      cmd(cfsa_pkg::INS_ACT, 8'h00, 8'h00, 8'h02, 8'h00, {16'h6F07, 112'h0}, 2, cfsa_pkg::SW_SEC_FAIL);
      chk({cur_ef, file_deact}, {3'h5, 8'h29});
      resolve(3'h3, 1'b1, 1'b0, 1'b1);
      cmd(cfsa_pkg::INS_ACT, 8'h00, 8'h00, 8'h02, 8'h00, {16'h6F07, 112'h0}, 2, cfsa_pkg::SW_OK);
      chk({cur_ef, file_deact}, {3'h3, 8'h21});
   endtask

   task automatic t_unblock();
      int r0;
      cmd(cfsa_pkg::INS_UNBLOCK, 8'h00, 8'h01, 8'h00, 8'h00, 128'h0, 0, {cfsa_pkg::SW_RETRY_HI, 4'h5});
      r0 = req_cnt;
      cmd(cfsa_pkg::INS_UNBLOCK, 8'h00, 8'h01, 8'h10, 8'h00, 128'h0123456789ABCDEFFEDCBA9876543210, 16,
         cfsa_pkg::SW_OK);
      chk(unblk_code, 64'h0123456789ABCDEF);
      chk(new_pin, 64'hFEDCBA9876543210);
      chk(req_cnt - r0, 1);
      cmd(cfsa_pkg::INS_UNBLOCK, 8'h00, 8'h01, 8'h08, 8'h00, 128'h0, 8, cfsa_pkg::SW_WRONG_LEN);
      chk(req_cnt - r0, 1);
   endtask

   task automatic t_auth();
      int r0;
      logic [7:0] b0;
      cmd(cfsa_pkg::INS_AUTH, 8'h00, 8'h00, 8'h02, 8'h02, {16'hA55A, 112'h0}, 2, cfsa_pkg::SW_COND_USE);
      @(posedge mclk);
      app_sel <= 1'b1;
      r0 = resp_cnt;
      cmd(cfsa_pkg::INS_AUTH, 8'h00, 8'h00, 8'h02, 8'h03, {16'hA55A, 112'h0}, 2, cfsa_pkg::SW_OK);
      chk(resp_cnt - r0, 3);
      chk({alg_imp, key_imp}, 2'b11);
      cmd(cfsa_pkg::INS_AUTH, 8'h00, 8'h85, 8'h01, 8'h01, {8'h3C, 120'h0}, 1, cfsa_pkg::SW_OK);
      chk({key_imp, key_spec, key_num}, {2'b01, 5'h05});
      cmd(cfsa_pkg::INS_AUTH, 8'h00, 8'h1F, 8'h01, 8'h01, {8'h3C, 120'h0}, 1, cfsa_pkg::SW_OK);
      chk({key_imp, key_spec, key_num}, {2'b00, 5'h1F});
      cmd(cfsa_pkg::INS_AUTH, 8'h00, 8'h41, 8'h01, 8'h01, {8'h3C, 120'h0}, 1, cfsa_pkg::SW_WRONG_P1P2);
      cmd(cfsa_pkg::INS_AUTH, 8'h00, 8'h80, 8'h01, 8'h01, {8'h3C, 120'h0}, 1, cfsa_pkg::SW_WRONG_P1P2);
      r0 = resp_cnt;
      cmd(cfsa_pkg::INS_AUTH, 8'h00, 8'h00, 8'h03, 8'h00, {16'hA55A, 112'h0}, 2, cfsa_pkg::SW_WRONG_LEN);
      chk(resp_cnt - r0, 0);
      cmd(cfsa_pkg::INS_AUTH, 8'h00, 8'h00, 8'h02, 8'h01, {16'hA55A, 112'h0}, 2, cfsa_pkg::SW_OK);
      b0 = resp_hold;
      cmd(cfsa_pkg::INS_AUTH, 8'h00, 8'h00, 8'h02, 8'h01, {16'h3C5A, 112'h0}, 2, cfsa_pkg::SW_OK);
      chk_ne(resp_hold, b0);
      @(posedge mclk);
      secret <= 8'h0F;
      cmd(cfsa_pkg::INS_AUTH, 8'h00, 8'h00, 8'h02, 8'h01, {16'hA55A, 112'h0}, 2, cfsa_pkg::SW_OK);
      chk_ne(resp_hold, b0);
   endtask

   task automatic conclude();
      if (error_cnt == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // main sequence
   initial begin
      {app_sel, found, acc_d, acc_r, op_req, tgt, op_file, op_kind} = '0;
      retries = 4'h5;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      @(negedge mclk);
      chk({busy, sw, cur_ef, file_deact}, 28'h0);
      t_deact_cur();
      t_files();
      t_unblock();
      t_auth();
      conclude();
   end
endmodule
`default_nettype wire
